//--- src/spmz_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  serial port (modes 0 and 1).
  Assumes it is included by bare name from the top module, the checker and the bench.
*/
`ifndef SPMZ_REGS_SVH
`define SPMZ_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SPMZ_ADDR_W 2
`define SPMZ_OFF_CTRL 2'h0
`define SPMZ_OFF_BUF 2'h1

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SPMZ_BIT_MODE 0
`define SPMZ_BIT_MULTI 1
`define SPMZ_BIT_RXEN 2
`define SPMZ_BIT_HALF 3
`define SPMZ_BIT_TXDONE 4
`define SPMZ_BIT_RXDONE 5
`define SPMZ_BIT_NINTH 6
`define SPMZ_CTRL_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing counts in oscillator clocks
// ----------------------------------------------------------------------------
`define SPMZ_M0_SLOW_LEAD 3
`define SPMZ_M0_SLOW_LOW 6
`define SPMZ_M0_FAST_LEAD 1
`define SPMZ_M0_FAST_LOW 2

`endif

//--- src/spmz_pkg.sv
/*
  Types shared by the serial port modules.
  Assumes spmz_regs.svh is on the include path.
*/
package spmz_pkg;
  typedef struct packed {
    logic half_rate;
    logic rx_enable_bit;
    logic multi_mode_bit;
    logic mode1;
  } spmz_ctrl_t;

  typedef enum logic [1:0] {
    SPMZ_M0_IDLE,
    SPMZ_M0_TX,
    SPMZ_M0_RX
  } spmz_m0_t;
endpackage

//--- src/spmz_baud.sv
/*
  Mode 1 baud tick: divides timer 1 overflow pulses by 1 or 2 so that the
  sixteen-slice counters run at 16 or 32 overflows per bit.
  Assumes OVF_TICK is a one-cycle pulse on SYS_CLK.
*/
`timescale 1ns/1ps
module spmz_baud (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic OVF_TICK,
  input wire logic HALF_RATE,
  output logic SLICE_TICK
);
  logic pre;

  // ---------------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------------
  // Toggle on each overflow; the half rate passes every second one.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pre <= 1'b0;
    end else if (OVF_TICK) begin
      pre <= ~pre;
    end
  end

  assign SLICE_TICK = OVF_TICK & (~HALF_RATE | pre);
endmodule // spmz_baud

//--- src/spmz_top.sv
/*
  Serial port, modes 0 and 1: shared buffer address, mode 0 shift engine,
  mode 1 transmitter and oversampled receiver.
  Assumes a same-clock register port with one-cycle strobes, a timer 1
  overflow pulse on SYS_CLK and an asynchronous serial data line.
*/
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "spmz_regs.svh"
module spmz_top (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [`SPMZ_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TIMER1_OVF,
  input wire logic RXD_IN,
  output logic RXD_OUT,
  output logic RXD_OE,
  output logic TXD
);
  spmz_pkg::spmz_ctrl_t ctrl;
  logic tx_done_flag;
  logic rx_done_flag;
  logic ninth_rx_bit;
  logic [7:0] rx_buffer;
  logic [7:0] next_rdata;
  logic rxd_meta;
  logic rxd_sync;
  logic rxd_prev;
  logic slice_tick;

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  // Flag clears come from a control write with the bit low; set wins below.
  wire wr_ctrl = WR & (ADDR == `SPMZ_OFF_CTRL);
  wire wr_buf = WR & (ADDR == `SPMZ_OFF_BUF);
  wire clr_tx = wr_ctrl & ~WDATA[`SPMZ_BIT_TXDONE];
  wire clr_rx = wr_ctrl & ~WDATA[`SPMZ_BIT_RXDONE];
  wire [7:0] ctrl_view = {1'b0, ninth_rx_bit, rx_done_flag, tx_done_flag,
                          ctrl.half_rate, ctrl.rx_enable_bit,
                          ctrl.multi_mode_bit, ctrl.mode1};

  // Read data come from a register one cycle later; unmapped reads zero.
  always_comb begin
    next_rdata = 8'h00;
    if (RD && ADDR == `SPMZ_OFF_CTRL) begin
      next_rdata = ctrl_view;
    end else if (RD && ADDR == `SPMZ_OFF_BUF) begin
      next_rdata = rx_buffer;
    end
  end

  // Control bits are written only by software.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl <= '0;
      RDATA <= 8'h00;
    end else begin
      RDATA <= next_rdata;
      if (wr_ctrl) begin
        ctrl <= spmz_pkg::spmz_ctrl_t'(WDATA[3:0]);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Receive line synchroniser
  // ---------------------------------------------------------------------------
  // The pin is asynchronous; only rxd_sync and later stages are read.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_prev <= 1'b1;
    end else begin
      rxd_meta <= RXD_IN;
      rxd_sync <= rxd_meta;
      rxd_prev <= rxd_sync;
    end
  end

  spmz_baud u_baud (
    .SYS_CLK(SYS_CLK),
    .NRST(NRST),
    .OVF_TICK(TIMER1_OVF),
    .HALF_RATE(ctrl.half_rate),
    .SLICE_TICK(slice_tick)
  );

  // ---------------------------------------------------------------------------
  // Mode 0 shift engine
  // ---------------------------------------------------------------------------
  // One bit takes lead + low + high clocks: 3+6+3 = 12 or 1+2+1 = 4.
  spmz_pkg::spmz_m0_t m0_state;
  logic [3:0] m0_phase;
  logic [2:0] m0_bit;
  logic [7:0] m0_shift;
  logic m0_clk;
  logic m0_tx_set;
  logic m0_rx_set;
  wire m0_fast = ctrl.multi_mode_bit;
  wire [3:0] m0_lead = m0_fast ? 4'(`SPMZ_M0_FAST_LEAD)
                               : 4'(`SPMZ_M0_SLOW_LEAD);
  wire [3:0] m0_low = m0_fast ? 4'(`SPMZ_M0_FAST_LOW)
                              : 4'(`SPMZ_M0_SLOW_LOW);
  wire [3:0] m0_last = 4'(m0_lead + m0_low + m0_lead - 4'h1);
  wire m0_fall = (m0_phase == 4'(m0_lead - 4'h1));
  wire m0_rise = (m0_phase == 4'(m0_lead + m0_low - 4'h1));
  wire m0_end = (m0_phase == m0_last);
  // A finished reception raises m0_rx_set one cycle before the flag itself
  // is set; looking at both keeps the engine from starting a second frame
  // in that gap, which would clock the partner with nobody reading.
  wire m0_rx_go = ~ctrl.mode1 & ctrl.rx_enable_bit & ~rx_done_flag
                & ~m0_rx_set;

  // Transmit or receive one byte with the device-made shift clock.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      m0_state <= spmz_pkg::SPMZ_M0_IDLE;
      m0_phase <= 4'h0;
      m0_bit <= 3'h0;
      m0_shift <= 8'h00;
      m0_clk <= 1'b1;
      m0_tx_set <= 1'b0;
      m0_rx_set <= 1'b0;
    end else begin
      m0_tx_set <= 1'b0;
      m0_rx_set <= 1'b0;
      case (m0_state)
        spmz_pkg::SPMZ_M0_IDLE: begin
          m0_phase <= 4'h0;
          m0_bit <= 3'h0;
          m0_clk <= 1'b1;
          if (!ctrl.mode1 && wr_buf) begin
            m0_shift <= WDATA;
            m0_state <= spmz_pkg::SPMZ_M0_TX;
          end else if (m0_rx_go) begin
            m0_state <= spmz_pkg::SPMZ_M0_RX;
          end
        end
        spmz_pkg::SPMZ_M0_TX, spmz_pkg::SPMZ_M0_RX: begin
          m0_phase <= m0_end ? 4'h0 : 4'(m0_phase + 4'h1);
          if (m0_fall) begin
            m0_clk <= 1'b0;
          end
          if (m0_rise) begin
            m0_clk <= 1'b1;
          end
          // The synchroniser lags the pin by two clocks, so at the fast
          // rate the level seen at the rise is still the previous bit.
          // Shifting at the last phase of the bit reads the level that the
          // partner set at the fall, at both rates; the partner holds it
          // until the next fall, which comes after this phase.
          if (m0_end) begin
            if (m0_state == spmz_pkg::SPMZ_M0_TX) begin
              m0_shift <= {1'b1, m0_shift[7:1]};
            end else begin
              m0_shift <= {rxd_sync, m0_shift[7:1]};
            end
            m0_bit <= 3'(m0_bit + 3'h1);
            if (m0_bit == 3'h7) begin
              m0_tx_set <= (m0_state == spmz_pkg::SPMZ_M0_TX);
              m0_rx_set <= (m0_state == spmz_pkg::SPMZ_M0_RX);
              m0_state <= spmz_pkg::SPMZ_M0_IDLE;
            end
          end
        end
        default: begin
          m0_state <= spmz_pkg::SPMZ_M0_IDLE;
        end
      endcase
    end
  end

  // Data line is driven only while sending; received data enter on RXD_IN.
  assign RXD_OUT = m0_shift[0];
  assign RXD_OE = (m0_state == spmz_pkg::SPMZ_M0_TX);

  // ---------------------------------------------------------------------------
  // Mode 1 transmitter
  // ---------------------------------------------------------------------------
  // Free-running sixteen-counter; bits change only on its rollover.
  logic [3:0] tx_div;
  logic tx_pend;
  logic tx_act;
  logic [8:0] tx_shift;
  logic [3:0] tx_cnt;
  logic tx_line;
  logic m1_tx_set;
  wire tx_roll = slice_tick & (tx_div == 4'hF);

  // A buffer write only arms the frame; the start bit waits for the next
  // rollover, so a frame may begin up to one bit time after the write.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_div <= 4'h0;
      tx_pend <= 1'b0;
      tx_act <= 1'b0;
      tx_shift <= 9'h1FF;
      tx_cnt <= 4'h0;
      tx_line <= 1'b1;
      m1_tx_set <= 1'b0;
    end else begin
      m1_tx_set <= 1'b0;
      if (slice_tick) begin
        tx_div <= 4'(tx_div + 4'h1);
      end
      if (ctrl.mode1 && wr_buf) begin
        tx_shift <= {1'b1, WDATA};
        tx_pend <= 1'b1;
      end else if (tx_roll && tx_pend) begin
        tx_pend <= 1'b0;
        tx_act <= 1'b1;
        tx_line <= 1'b0;
        tx_cnt <= 4'h1;
      end else if (tx_roll && tx_act) begin
        tx_line <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[8:1]};
        tx_cnt <= 4'(tx_cnt + 4'h1);
        if (tx_cnt == 4'h9) begin
          tx_act <= 1'b0;
          m1_tx_set <= 1'b1;
        end
      end
    end
  end

  // In mode 0 the pin carries the shift clock; both sources idle high, so
  // a mode change between frames makes no edge on the line.
  assign TXD = ctrl.mode1 ? tx_line : m0_clk;

  // ---------------------------------------------------------------------------
  // Mode 1 receiver
  // ---------------------------------------------------------------------------
  // The sixteen-counter only runs inside a frame; between frames it waits
  // for a falling edge on the synchronised line.
  logic rx_act;
  logic [3:0] rx_div;
  logic [3:0] rx_cnt;
  logic [2:0] votes;
  logic [8:0] rx_shift;
  logic m1_rx_set;
  wire voted = (votes[0] & votes[1]) | (votes[1] & votes[2])
             | (votes[0] & votes[2]);
  wire rx_edge = rxd_prev & ~rxd_sync;
  wire sample_slot = (rx_div >= 4'h7) & (rx_div <= 4'h9);
  // Votes are taken in slices 7, 8 and 9; the bit is decided one slice
  // later so that the third vote is already in the register.
  wire decide = slice_tick & (rx_div == 4'hA);
  wire rx_keep = ~rx_done_flag & (~ctrl.multi_mode_bit | voted);

  // Start on an edge, vote each bit, give up on a bad start bit and stop
  // at the middle of the stop bit, ready for the next edge.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_act <= 1'b0;
      rx_div <= 4'h0;
      rx_cnt <= 4'h0;
      votes <= 3'h0;
      rx_shift <= 9'h000;
      m1_rx_set <= 1'b0;
    end else begin
      m1_rx_set <= 1'b0;
      if (!rx_act) begin
        if (ctrl.mode1 && ctrl.rx_enable_bit && rx_edge) begin
          rx_act <= 1'b1;
          rx_div <= 4'h0;
          rx_cnt <= 4'h0;
        end
      end else if (slice_tick) begin
        rx_div <= 4'(rx_div + 4'h1);
        if (sample_slot) begin
          votes <= {votes[1:0], rxd_sync};
        end
        if (decide) begin
          rx_cnt <= 4'(rx_cnt + 4'h1);
          rx_shift <= {voted, rx_shift[8:1]};
          if (rx_cnt == 4'h0 && voted) begin
            rx_act <= 1'b0;
          end else if (rx_cnt == 4'h9) begin
            rx_act <= 1'b0;
            m1_rx_set <= rx_keep;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Receive buffer and done flags
  // ---------------------------------------------------------------------------
  // Hardware set beats a software clear in the same cycle.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      ninth_rx_bit <= 1'b0;
      rx_buffer <= 8'h00;
    end else begin
      if (m0_tx_set || m1_tx_set) begin
        tx_done_flag <= 1'b1;
      end else if (clr_tx) begin
        tx_done_flag <= 1'b0;
      end
      if (m0_rx_set || m1_rx_set) begin
        rx_done_flag <= 1'b1;
      end else if (clr_rx) begin
        rx_done_flag <= 1'b0;
      end
      if (m0_rx_set) begin
        rx_buffer <= m0_shift;
      end else if (m1_rx_set) begin
        // Ten shifts leave the stop bit on top and D0 at the bottom.
        rx_buffer <= rx_shift[7:0];
        ninth_rx_bit <= voted;
      end
    end
  end
endmodule // spmz_top

//--- testbench/spmz_top_monitor.sv
/*
  Checker for the serial port top: mode 0 clock shape and control access.
  Assumes spmz_regs.svh on the include path; bound to every spmz_top.
*/
`timescale 1ns/1ps
`include "spmz_regs.svh"
module spmz_top_monitor (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [`SPMZ_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic TIMER1_OVF,
  input wire logic RXD_IN,
  input wire logic RXD_OUT,
  input wire logic RXD_OE,
  input wire logic TXD
);
  logic [7:0] ctl;

  // -------------------------------------------
  // Control shadow and checks
  // -------------------------------------------
  // Shadow of the control byte, since mode and rate set the clock shape.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) ctl <= `SPMZ_CTRL_RESET;
    else if (WR && ADDR == `SPMZ_OFF_CTRL) ctl <= WDATA;
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence s_tx_fall;
    !ctl[0] && RXD_OE && $fell(TXD);
  endsequence
  sequence s_low_2;
    !TXD ##1 TXD;
  endsequence
  sequence s_low_6;
    !TXD [*5] ##1 TXD;
  endsequence

  a_reset_idle: assert property ($rose(NRST) |-> TXD && !RXD_OE)
    else $error("outputs not idle after reset");
  a_ctrl_read: assert property (
    RD && ADDR == `SPMZ_OFF_CTRL |=> RDATA[3:0] == ctl[3:0] && !RDATA[7])
    else $error("control read back wrong");
  a_fast_low: assert property (
    ctl[1] ##0 s_tx_fall |=> s_low_2) else $error("fast clock low time");
  a_slow_low: assert property (
    !ctl[1] ##0 s_tx_fall |=> s_low_6) else $error("slow clock low time");
  a_fast_lead: assert property (
    ctl[1] ##0 s_tx_fall |-> $stable(RXD_OUT)) else $error("fast data lead");
  a_slow_lead: assert property (
    !ctl[1] ##0 s_tx_fall |-> $past(RXD_OUT, 3) == RXD_OUT)
    else $error("slow data lead");
  a_rx_clock: assert property (
    WR && ADDR == `SPMZ_OFF_CTRL && WDATA[2:0] == 3'h6 && !WDATA[5]
    |-> ##[1:16] $fell(TXD)) else $error("receive clock not started");
  a_oe_mode_one: assert property (
    ctl[0] && $past(ctl[0]) |-> !RXD_OE) else $error("data driven in mode 1");
endmodule // spmz_top_monitor

bind spmz_top spmz_top_monitor i_mon (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .TIMER1_OVF(TIMER1_OVF), .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT),
  .RXD_OE(RXD_OE), .TXD(TXD));

//--- testbench/spmz_far.sv
/*
  Far-side serial device: mode 0 shift register and mode 1 line partner.
  Assumes the bench tells it the mode and joins the data line through din.
*/
`timescale 1ns/1ps
module spmz_far (
  input wire logic clk,
  input wire logic mode1,
  input wire logic [7:0] m0_byte,
  input wire logic txd,
  input wire logic dout,
  input wire logic oe,
  output logic din,
  output logic [7:0] cap
);
  logic drv = 1'b1;
  logic [2:0] idx = 3'h0;

  // -------------------------------------------
  // Line behaviour
  // -------------------------------------------
  // The wire follows the port while it drives, else this device.
  assign din = oe ? dout : drv;
  // Bits change on the falling clock so they are settled at the rise.
  always @(negedge txd) begin
    if (!oe && !mode1) begin
      drv <= m0_byte[idx];
      idx <= idx + 3'h1;
    end
  end
  // Bits from the port are taken on the rising shift clock.
  always @(posedge txd) begin
    if (oe) cap <= {dout, cap[7:1]};
  end
  // Frame out: idle, start, data LSB first, stop, idle again.
  task automatic send(input logic [9:0] f, input int bt);
    for (int i = 0; i < 12; i++) begin
      drv <= (i == 0 || i == 11) ? 1'b1 : f[i-1];
      repeat (bt) @(posedge clk);
    end
  endtask
  // Frame in: sample each bit at its middle, ending mid stop bit.
  task automatic get(output logic [9:0] f, input int bt);
    @(negedge txd);
    for (int i = 0; i < 10; i++) begin
      repeat (i ? bt : bt / 2) @(posedge clk);
      f[i] = txd;
    end
  endtask
endmodule // spmz_far

//--- testbench/spmz_top_test.sv
/*
  Self-checking bench for the serial port in modes 0 and 1.
  Assumes spmz_top, spmz_far and the checker are compiled before it.
*/
`timescale 1ns/1ps
`include "spmz_regs.svh"
module spmz_top_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ovf = 1'b0;
  logic mode1 = 1'b0;
  logic [2:0] oc = 3'h0;
  logic [7:0] rdata, cap, d;
  logic rxd_in, rxd_out, rxd_oe, txd;
  logic [9:0] f;
  int fail_count = 0;
  int comparisons = 0;
  int nfall = 0;
  time tf, tl;

  spmz_top i_dut (.SYS_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TIMER1_OVF(ovf), .RXD_IN(rxd_in),
    .RXD_OUT(rxd_out), .RXD_OE(rxd_oe), .TXD(txd));
  spmz_far i_far (.clk(clk), .mode1(mode1), .m0_byte(8'h6B), .txd(txd),
    .dout(rxd_out), .oe(rxd_oe), .din(rxd_in), .cap(cap));

  // -------------------------------------------
  // Clock, slice tick and helpers
  // -------------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  // Overflow pulse every 8 cycles gives a 400 ns slice tick, 800 ns at half rate.
  always @(posedge clk) begin
    oc <= oc + 3'h1;
    ovf <= (oc == 3'h7);
  end
  // Shift clock falls are timed so the bit rate can be checked.
  always @(negedge txd) begin
    if (nfall == 0) tf = $time;
    tl = $time;
    nfall++;
  end
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hang past three times the expected run length ends the test.
  initial begin
    #2000000;
    fail_count++;
    report_and_stop();
  end

  // -------------------------------------------
  // Scenarios
  // -------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(`SPMZ_OFF_CTRL, d);
    chk(10'(d), 10'h000);
    rd_reg(2'h3, d);
    chk(10'(d), 10'h000);
    // Mode 0 sends at the fast rate, then the slow one.
    for (int k = 0; k < 2; k++) begin
      nfall = 0;
      wr_reg(`SPMZ_OFF_CTRL, k ? 8'h00 : 8'h02);
      wr_reg(`SPMZ_OFF_BUF, k ? 8'h3C : 8'hA5);
      repeat (k ? 120 : 40) @(posedge clk);
      chk(10'(nfall), 10'h008);
      chk(10'((tl - tf) / 50), k ? 10'h054 : 10'h01C);
      chk(10'(cap), k ? 10'h03C : 10'h0A5);
      rd_reg(`SPMZ_OFF_CTRL, d);
      chk(10'(d[4]), 10'h001);
    end
    // Mode 0 receive; the set flag must keep the clock still.
    wr_reg(`SPMZ_OFF_CTRL, 8'h06);
    repeat (50) @(posedge clk);
    rd_reg(`SPMZ_OFF_BUF, d);
    chk(10'(d), 10'h06B);
    rd_reg(`SPMZ_OFF_CTRL, d);
    nfall = 0;
    chk(10'(d[5]), 10'h001);
    repeat (20) @(posedge clk);
    chk(10'(nfall), 10'h000);
    // Mode 1 sends at overflow/16, then overflow/32.
    mode1 <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr_reg(`SPMZ_OFF_CTRL, k ? 8'h09 : 8'h01);
      wr_reg(`SPMZ_OFF_BUF, k ? 8'h81 : 8'hC4);
      i_far.get(f, k ? 256 : 128);
      chk(f, {1'b1, (k ? 8'h81 : 8'hC4), 1'b0});
      rd_reg(`SPMZ_OFF_CTRL, d);
      chk(10'(d[4]), 10'h001);
    end
    // Mode 1 receive, then a frame lost while the flag is still set.
    wr_reg(`SPMZ_OFF_CTRL, 8'h05);
    i_far.send({1'b1, 8'h96, 1'b0}, 128);
    rd_reg(`SPMZ_OFF_BUF, d);
    chk(10'(d), 10'h096);
    rd_reg(`SPMZ_OFF_CTRL, d);
    chk(10'(d[6:5]), 10'h003);
    i_far.send({1'b1, 8'h11, 1'b0}, 128);
    rd_reg(`SPMZ_OFF_BUF, d);
    chk(10'(d), 10'h096);
    // Short glitch, a zero stop bit under multi_mode_bit, then a good frame.
    wr_reg(`SPMZ_OFF_CTRL, 8'h07);
    i_far.send(10'h3FE, 48);
    i_far.send({1'b0, 8'h22, 1'b0}, 128);
    i_far.send({1'b1, 8'h5A, 1'b0}, 128);
    rd_reg(`SPMZ_OFF_BUF, d);
    chk(10'(d), 10'h05A);
    // With reception off a frame must leave buffer and flag alone.
    wr_reg(`SPMZ_OFF_CTRL, 8'h01);
    i_far.send({1'b1, 8'h77, 1'b0}, 128);
    rd_reg(`SPMZ_OFF_BUF, d);
    chk(10'(d), 10'h05A);
    rd_reg(`SPMZ_OFF_CTRL, d);
    chk(10'(d[5]), 10'h000);
    report_and_stop();
  end
endmodule // spmz_top_test
